/* File: src/low_power_mode_control.v */
// Low power mode controller: Sleep, Software Standby and Snooze sequencing,
// operating power control mode selection, oscillator dividers, module stops.
// Assumes one clock, a synchronous reset that stands for any reset source,
// and an AHB-Lite slave port with a single slave on the bus.
//
// Overview of operation
// - Sleep halts the CPU only; peripherals and clock sources keep running.
// - Snooze keeps the CPU halted; selected peripherals may request clocks.
// - Software Standby stops CPU, most peripherals and clock sources.
// - Wait-for-interrupt with standby select clear enters Sleep.
// - Wait-for-interrupt with standby select set enters Software Standby.
// - Snooze is entered only from Standby on a snooze request, select set.
// - Sleep ends on any interrupt or any reset.
// - Standby and Snooze end only on enabled wake interrupts, NMI or reset.
// - Interrupt wake resumes execution by servicing that interrupt.
// - Reset wake goes to reset state, not resumed execution.
// - With clock source bit 0, mode field 11/10/01 picks high/middle/low.
// - Clock source bit 1 forces subclock-speed mode regardless of field.
// - Selected power control mode applies in Normal, Sleep and Snooze.
// - Divider ratios selectable for fast, mid and main crystal oscillators.
// - Each peripheral module can be stopped independently.
// - Stop bit 0 starts a module, 1 stops it; stopped registers inaccessible.
`timescale 1ns/100ps
`include "lpm_consts.vh"

module low_power_mode_control
(
    input  wire        clock,                // System clock, 50 MHz.
    input  wire        srst,                 // Synchronous reset, any source.
    input  wire        clk_en,               // Clock enable, freezes state when low.
    input  wire        hsel,                 // AHB-Lite slave select.
    input  wire [11:0] haddr,                // AHB-Lite address.
    input  wire [1:0]  htrans,               // AHB-Lite transfer type.
    input  wire        hwrite,               // AHB-Lite write.
    input  wire [2:0]  hsize,                // AHB-Lite size.
    input  wire        hready,               // AHB-Lite bus ready.
    input  wire [31:0] hwdata,               // AHB-Lite write data.
    output wire [31:0] hrdata,               // AHB-Lite read data.
    output wire        hreadyout,            // AHB-Lite slave ready.
    output wire        hresp,                // AHB-Lite response, always OKAY.
    input  wire        wfi,                  // CPU executes wait-for-interrupt, pulse.
    input  wire        snooze_request,       // Snooze request trigger.
    input  wire [15:0] irq,                  // Interrupt requests, level.
    input  wire        nmi,                  // Non-maskable interrupt, level.
    input  wire        clock_source_state_bit, // Core clock on subclock when 1.
    output reg         cpu_halt,             // CPU halted.
    output reg         periph_clk_gate,      // Peripheral clocks gated off.
    output reg         osc_stop,             // Clock sources stopped.
    output reg         snooze_clk_allow,     // Selected peripherals may run clocks.
    output reg         wake_service,         // Pulse: service the waking interrupt.
    output reg         reset_req,            // Pulse: reset ended a low power state.
    output reg  [1:0]  power_ctrl_mode,      // Effective power control mode.
    output reg  [15:0] module_stop,          // Per-module stop, 1 = stopped.
    output reg  [2:0]  fast_osc_div,         // Divider for fast internal osc.
    output reg  [2:0]  mid_osc_div,          // Divider for mid internal osc.
    output reg  [2:0]  main_osc_div          // Divider for main crystal osc.
);

    // ============================================================
    // Registers
    reg         standby_select_bit;
    reg  [1:0]  operating_power_mode_reg;
    reg  [15:0] wake_enable;
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg         ph_valid;
    reg         ph_write;
    reg  [11:0] ph_addr;
    reg  [31:0] rdata;

    wire        any_irq  = |irq;
    wire        take     = hsel & hready & htrans[1];
    wire [15:0] wake_hit;
    wire        wake_sel;
    genvar      g;

    // ============================================================
    // Wake source qualification
    // Each interrupt line is gated by its own enable bit before it may end
    // Software Standby or Snooze. Keeping one gate per line makes it easy to
    // give a line a different qualification later without touching the rest.
    // The non-maskable request bypasses the enables on purpose: software can
    // never lock the part in a deep state by clearing every enable bit.
    generate
        for (g = 0; g < `NUM_IRQ; g = g + 1)
        begin : g_wake
            assign wake_hit[g] = irq[g] & wake_enable[g];
        end
    endgenerate

    assign wake_sel = nmi | (|wake_hit);

    // True in any of the three low power states.
    function is_low_power;
        input [1:0] st;
        begin
            is_low_power = (st != `ST_NORMAL);
        end
    endfunction

    // Decode of the effective power control mode.
    function [1:0] eff_mode;
        input [1:0] field;
        input       subclk;
        begin
            if (subclk)
                eff_mode = `PM_SUBOSC;
            else if (field == 2'h0)
                eff_mode = `PM_LOW;
            else
                eff_mode = field;
        end
    endfunction

    // ============================================================
    // State machine
    // Sleep is left on any request because every clock still runs there and
    // the core can take the interrupt at once. Standby and Snooze listen only
    // to the qualified sources. A wake in Standby wins over a snooze request
    // arriving in the same cycle, so a pending interrupt is never delayed by
    // a detour through Snooze.
    always @*
    begin
        next_state = state;
        case (state)
            `ST_NORMAL:
            begin
                if (wfi && standby_select_bit)
                    next_state = `ST_STANDBY;
                else if (wfi)
                    next_state = `ST_SLEEP;
            end
            `ST_SLEEP:
            begin
                if (any_irq || nmi)
                    next_state = `ST_NORMAL;
            end
            `ST_STANDBY:
            begin
                if (wake_sel)
                    next_state = `ST_NORMAL;
                else if (snooze_request && standby_select_bit)
                    next_state = `ST_SNOOZE;
            end
            `ST_SNOOZE:
            begin
                if (wake_sel)
                    next_state = `ST_NORMAL;
            end
            default:
                next_state = `ST_NORMAL;
        endcase
    end

    // Any reset ends a low power state and returns the controller to Normal.
    always @(posedge clock)
    begin
        if (srst)
        begin
            state        <= `ST_NORMAL;
            wake_service <= 1'b0;
            // Flags for one cycle that a reset, not an interrupt, ended a low power state.
            reset_req    <= is_low_power(state);
        end
        else if (clk_en)
        begin
            state        <= next_state;
            wake_service <= is_low_power(state) && !is_low_power(next_state);
            reset_req    <= 1'b0;
        end
    end

    // Outputs are registered from next_state, so they drop on the same edge as the state leaves low power.
    always @(posedge clock)
    begin
        if (srst)
        begin
            cpu_halt         <= 1'b0;
            periph_clk_gate  <= 1'b0;
            osc_stop         <= 1'b0;
            snooze_clk_allow <= 1'b0;
            power_ctrl_mode  <= `PM_HIGH;
        end
        else if (clk_en)
        begin
            cpu_halt         <= is_low_power(next_state);
            periph_clk_gate  <= (next_state == `ST_STANDBY) ||
                                (next_state == `ST_SNOOZE);
            osc_stop         <= (next_state == `ST_STANDBY);
            snooze_clk_allow <= (next_state == `ST_SNOOZE);
            power_ctrl_mode  <= eff_mode(operating_power_mode_reg,
                                         clock_source_state_bit);
        end
    end

    // ============================================================
    // AHB-Lite slave, zero wait states
    // The slave never stretches a transfer, so the bus never waits on this
    // block even while the core is halted. Only the address phase is stored;
    // write data is taken from the bus in the following data phase.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata;

    always @(posedge clock)
    begin
        if (srst)
        begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr  <= 12'h000;
        end
        else if (clk_en && hready)
        begin
            ph_valid <= take;
            ph_write <= hwrite;
            ph_addr  <= haddr;
        end
    end

    always @(posedge clock)
    begin
        if (srst)
        begin
            standby_select_bit       <= 1'b0;
            operating_power_mode_reg <= `RST_POWER_MODE;
            wake_enable              <= `RST_WAKE_ENABLE;
            module_stop              <= `RST_MODULE_STOP;
            fast_osc_div             <= 3'h0;
            mid_osc_div              <= 3'h0;
            main_osc_div             <= 3'h0;
        end
        else if (clk_en && ph_valid && ph_write)
        begin
            case (ph_addr)
                `OFS_STANDBY_CTRL:
                    standby_select_bit <= hwdata[`STANDBY_SELECT_POS];
                `OFS_POWER_MODE:
                    operating_power_mode_reg <= hwdata[1:0];
                `OFS_OSC_DIV:
                begin
                    fast_osc_div <= hwdata[`DIV_FAST_LSB +: `DIV_W];
                    mid_osc_div  <= hwdata[`DIV_MID_LSB +: `DIV_W];
                    main_osc_div <= hwdata[`DIV_MAIN_LSB +: `DIV_W];
                end
                `OFS_MODULE_STOP:
                    module_stop <= hwdata[15:0];
                `OFS_WAKE_ENABLE:
                    wake_enable <= hwdata[15:0];
                default:
                    standby_select_bit <= standby_select_bit;
            endcase
        end
    end

    // Read data is registered in the address phase so it stands in the data phase.
    always @(posedge clock)
    begin
        if (srst)
            rdata <= 32'h00000000;
        else if (clk_en && hready)
        begin
            rdata <= 32'h00000000;
            if (take && !hwrite)
            begin
                case (haddr)
                    `OFS_STANDBY_CTRL:
                        rdata <= {31'h00000000, standby_select_bit};
                    `OFS_POWER_MODE:
                        rdata <= {30'h00000000, operating_power_mode_reg};
                    `OFS_CLK_SRC_STATUS:
                        rdata <= {31'h00000000, clock_source_state_bit};
                    `OFS_OSC_DIV:
                        rdata <= {21'h000000, main_osc_div, 1'b0, mid_osc_div,
                                  1'b0, fast_osc_div};
                    `OFS_MODULE_STOP:
                        rdata <= {16'h0000, module_stop};
                    `OFS_WAKE_ENABLE:
                        rdata <= {16'h0000, wake_enable};
                    `OFS_STATUS:
                        rdata <= {28'h0000000, power_ctrl_mode, state};
                    default:
                        rdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // low_power_mode_control

/* File: src/lpm_consts.vh */
// Constants for the low power mode controller: register offsets, field
// positions, reset values and state codes.
// Assumes inclusion by bare name from the design file.
`ifndef LPM_CONSTS_VH
`define LPM_CONSTS_VH

// ============================================================
// Register byte offsets
`define OFS_STANDBY_CTRL     12'h000
`define OFS_POWER_MODE       12'h004
`define OFS_CLK_SRC_STATUS   12'h008
`define OFS_OSC_DIV          12'h00c
`define OFS_MODULE_STOP      12'h010
`define OFS_WAKE_ENABLE      12'h014
`define OFS_STATUS           12'h018

// ============================================================
// Field positions and widths
`define STANDBY_SELECT_POS   0
`define CLOCK_SOURCE_POS     0
`define MODE_LSB             0
`define DIV_FAST_LSB         0
`define DIV_MID_LSB          4
`define DIV_MAIN_LSB         8
`define DIV_W                3
`define NUM_MODULES          16
`define NUM_IRQ              16

// ============================================================
// Reset values
`define RST_POWER_MODE       2'h3
`define RST_MODULE_STOP      16'hfffe
`define RST_OSC_DIV          12'h000
`define RST_WAKE_ENABLE      16'h0000

// ============================================================
// Power control mode encodings
`define PM_HIGH              2'h3
`define PM_MIDDLE            2'h2
`define PM_LOW               2'h1
`define PM_SUBOSC            2'h0

// ============================================================
// Low power states
`define ST_NORMAL            2'h0
`define ST_SLEEP             2'h1
`define ST_STANDBY           2'h2
`define ST_SNOOZE            2'h3

`endif

/* File: verif/lpm_ctrl_sva.sv */
// Checker for the low power mode controller, seeing its ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module lpm_ctrl_sva
(
    input wire        clock,                  // Clock.
    input wire        srst,                   // Reset.
    input wire        clk_en,                 // Enable.
    input wire        wfi,                    // Wait pulse.
    input wire [15:0] irq,                    // Interrupts.
    input wire        nmi,                    // NMI.
    input wire        clock_source_state_bit, // Subclock.
    input wire        cpu_halt,               // Halt.
    input wire        periph_clk_gate,        // Gate.
    input wire        osc_stop,               // Osc off.
    input wire        snooze_clk_allow,       // Snooze.
    input wire        wake_service,           // Wake pulse.
    input wire [1:0]  power_ctrl_mode         // Mode.
);
    // ============================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    wire sleeping = cpu_halt && !periph_clk_gate;
    sequence s_wake;
        !cpu_halt && wake_service ##1 !wake_service;
    endsequence
    AST_ENTRY: assert property ($rose(cpu_halt) |-> $past(wfi))
        else $error("halt without wfi");
    AST_WFI_HALT: assert property (wfi && clk_en && !cpu_halt |=> cpu_halt)
        else $error("wfi ignored");
    AST_SLEEP: assert property (sleeping |-> !osc_stop && !snooze_clk_allow)
        else $error("sleep stops clocks");
    AST_STANDBY: assert property (osc_stop |-> cpu_halt && periph_clk_gate)
        else $error("standby incomplete");
    AST_SNOOZE: assert property (snooze_clk_allow |-> periph_clk_gate && !osc_stop)
        else $error("snooze outputs wrong");
    AST_SNOOZE_FROM: assert property ($rose(snooze_clk_allow) |-> $past(osc_stop))
        else $error("snooze not from standby");
    AST_SLEEP_WAKE: assert property (sleeping && clk_en && (|irq || nmi) |=> s_wake)
        else $error("sleep wake wrong");
    AST_NMI_WAKE: assert property (periph_clk_gate && clk_en && nmi |=> s_wake)
        else $error("nmi wake wrong");
    AST_NO_WAKE: assert property (periph_clk_gate && !nmi && irq == 16'h0000 |=> cpu_halt)
        else $error("spurious wake");
    AST_SUBCLK: assert property ((clock_source_state_bit && clk_en)[*2] |=>
        power_ctrl_mode == 2'h0)
        else $error("subclock mode wrong");
    AST_WAKE_SRC: assert property (wake_service |-> $past(cpu_halt))
        else $error("wake outside low power");
endmodule // lpm_ctrl_sva

/* File: verif/lpm_core_model.sv */
// Core-side model: issues wait-for-interrupt, snooze triggers and wakes.
// Assumes the controller's clock; drives only right after rising edges.
`timescale 1ns/100ps
module lpm_core_model
(
    input  wire        clock,          // Clock.
    input  wire        wake_service,   // Wake pulse.
    output reg         wfi,            // Wait pulse.
    output reg         snooze_request, // Snooze trigger.
    output reg  [15:0] irq,            // Interrupts.
    output reg         nmi             // NMI.
);
    initial {wfi, snooze_request, irq, nmi} = 19'h0;
    task run_wfi;
        @(posedge clock) wfi <= 1'b1;
        @(posedge clock) wfi <= 1'b0;
        @(posedge clock);
    endtask
    task snooze;
        @(posedge clock) snooze_request <= 1'b1;
        @(posedge clock) snooze_request <= 1'b0;
        @(posedge clock);
    endtask
    // The source is withdrawn after four cycles, whether serviced or not.
    task raise(input [15:0] v, input n, output logic woke);
        woke = 1'b0;
        @(posedge clock) irq <= v;
        nmi <= n;
        repeat (4) @(posedge clock) if (wake_service === 1'b1) woke = 1'b1;
        irq <= 16'h0000;
        nmi <= 1'b0;
    endtask
endmodule // lpm_core_model

/* File: verif/test_low_power_mode_control.sv */
// Bench for the low power mode controller: AHB-Lite tasks and core model.
// Assumes the controller answers with zero wait states.
`timescale 1ns/100ps
module test_low_power_mode_control;
    reg         clock = 1'b0;
    reg         srst = 1'b1;
    reg         clk_en = 1'b1;
    reg         hsel = 1'b0;
    reg         hwrite = 1'b0;
    reg  [1:0]  htrans = 2'h0;
    reg  [11:0] haddr = 12'h000;
    reg  [31:0] hwdata = 32'h00000000;
    reg         csb = 1'b0;
    wire [31:0] hrdata;
    wire [15:0] irq, mstop;
    wire [2:0]  dfa, dmi, dma;
    wire [1:0]  pcm;
    wire        hrdy, wfi, snz, nmi, halt, pcg, ostop, sca, wake, hrsp, rreq;
    integer     err_total = 0;
    integer     num_checks = 0;
    integer     i;
    logic [31:0] rd;
    logic       woke;
    always #10 clock = ~clock;
    low_power_mode_control u_dut (.clock(clock), .srst(srst), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hrdy),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hrsp), .wfi(wfi),
        .snooze_request(snz), .irq(irq), .nmi(nmi), .clock_source_state_bit(csb),
        .cpu_halt(halt), .periph_clk_gate(pcg), .osc_stop(ostop), .snooze_clk_allow(sca),
        .wake_service(wake), .reset_req(rreq), .power_ctrl_mode(pcm), .module_stop(mstop),
        .fast_osc_div(dfa), .mid_osc_div(dmi), .main_osc_div(dma));
    lpm_core_model u_core (.clock(clock), .wake_service(wake), .wfi(wfi),
        .snooze_request(snz), .irq(irq), .nmi(nmi));
    // ============================================================
    // Tasks
    task chk(input string nm, input [31:0] s, input [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task bus(input w, input [11:0] a, input [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ============================================================
    // Tests
    initial
    begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        bus(0, 12'h010, 0); chk("stop_rst", rd, 32'hfffe);
        chk("hresp", {hrdy, hrsp}, 2'h2);
        bus(1, 12'h01c, 32'hffffffff); bus(0, 12'h01c, 0); chk("unmapped", rd, 0);
        bus(1, 12'h00c, 32'h765); bus(0, 12'h00c, 0); chk("div_rd", rd, 32'h765);
        chk("div", {1'b0, dma, 1'b0, dmi, 1'b0, dfa}, 32'h765);
        bus(1, 12'h010, 32'h5a5a); @(posedge clock); chk("stop", mstop, 32'h5a5a);
        for (i = 1; i < 4; i++)
        begin
            bus(1, 12'h004, i); repeat (2) @(posedge clock); chk("mode", pcm, i);
        end
        csb <= 1'b1; repeat (3) @(posedge clock); chk("subclk", pcm, 0);
        csb <= 1'b0;
        bus(1, 12'h000, 0); u_core.run_wfi;
        chk("sleep", {halt, pcg, ostop, sca}, 4'h8);
        chk("sleep_mode", pcm, 3);
        u_core.raise(16'h8000, 0, woke); chk("sleep_wake", {woke, halt}, 2'h2);
        bus(1, 12'h014, 32'h4); bus(1, 12'h000, 1); u_core.run_wfi;
        chk("stby", {halt, pcg, ostop, sca}, 4'he);
        u_core.raise(16'h0001, 0, woke); chk("refuse", {woke, halt}, 2'h1);
        u_core.snooze; chk("snooze", {halt, pcg, ostop, sca}, 4'hd);
        bus(0, 12'h018, 0); chk("state", rd & 32'h3, 3);
        u_core.raise(16'h0004, 0, woke); chk("snz_wake", {woke, halt, sca}, 3'h4);
        u_core.snooze; chk("snz_normal", sca, 0);
        u_core.run_wfi; u_core.raise(0, 1, woke); chk("nmi_wake", {woke, halt}, 2'h2);
        clk_en <= 1'b0; u_core.run_wfi; chk("frozen", halt, 0);
        clk_en <= 1'b1;
        u_core.run_wfi; srst <= 1'b1; repeat (2) @(posedge clock);
        chk("rst_req", rreq, 1);
        srst <= 1'b0;
        @(posedge clock); chk("rst_wake", {halt, wake, mstop}, 18'h0fffe);
        final_report;
    end
    initial
    begin
        #400000;
        err_total++;
        final_report;
    end
endmodule // test_low_power_mode_control
bind low_power_mode_control lpm_ctrl_sva u_sva (.clock(clock), .srst(srst), .clk_en(clk_en),
    .wfi(wfi), .irq(irq), .nmi(nmi), .clock_source_state_bit(clock_source_state_bit),
    .cpu_halt(cpu_halt), .periph_clk_gate(periph_clk_gate), .osc_stop(osc_stop),
    .snooze_clk_allow(snooze_clk_allow), .wake_service(wake_service),
    .power_ctrl_mode(power_ctrl_mode));
